// ---- rtl/sgf_global_ctrl.sv ----
`timescale 1ns/100ps
module sgf_global_ctrl #(
    parameter logic [31:0] FAST_AGE_CYCLES = 32'(sgf_pkg::SGF_FAST_AGE_CYC),
    parameter logic [31:0] NORM_AGE_CYCLES = 32'(sgf_pkg::SGF_NORM_AGE_CYC)
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic size_check_strap_pin_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // modes from elsewhere in the switch
    input wire logic sniffer_mode_i,
    input wire logic multi_queue_i,
    // frame size and length check request
    input wire logic frm_valid_i,
    input wire logic [10:0] frm_len_i,
    input wire logic frm_tagged_i,
    input wire logic [15:0] frm_len_type_i,
    input wire logic frm_bad_i,
    output logic frm_done_o,
    output logic frm_drop_o,
    // storm regulation qualifier
    input wire logic storm_valid_i,
    input wire logic [47:0] storm_da_i,
    output logic storm_count_o,
    // port-vlan forwarding
    input wire logic fwd_valid_i,
    input wire logic fwd_known_uc_i,
    input wire logic fwd_same_vlan_i,
    output logic fwd_done_o,
    output logic fwd_allow_o,
    // excessive collision and fair mode
    input wire logic coll_valid_i,
    input wire logic [4:0] coll_cnt_i,
    output logic coll_drop_o,
    output logic coll_retry_o,
    input wire logic contention_i,
    output logic drop_nonfc_o,
    output logic throttle_fc_o,
    // aging
    output logic age_tick_o,
    // configuration levels
    output logic pass_all_o,
    output logic tx_pause_en_o,
    output logic rx_pause_en_o,
    output logic aggr_backoff_o,
    output logic mirror_allowed_o,
    output logic bp_carrier_o,
    output logic [5:0] rsv_hi_bufs_o
);
    import sgf_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] flow;
        logic [7:0] size;
        logic [7:0] rdata;
        logic rvalid;
        logic frm_done;
        logic frm_drop;
        logic storm;
        logic fwd_done;
        logic fwd_allow;
        logic coll_drop;
        logic coll_retry;
        logic drop_nonfc;
        logic throttle_fc;
        logic [31:0] age_cnt;
        logic age_tick;
        logic pass_all;
        logic mirror_ok;
        logic [5:0] rsv_bufs;
    } sgf_state_s;

    sgf_state_s state_ff;
    sgf_state_s nxt_state;

    logic [10:0] max_len;
    logic [15:0] exp_len;
    logic [15:0] payload;
    logic too_long;
    logic len_bad;
    logic [31:0] age_period;

    // ----------------------------------------------------------------
    // frame limits
    // ----------------------------------------------------------------
    // size limit chosen by the huge and legal size bits
    always_comb begin
        if (state_ff.size[SGF_S_HUGE]) begin
            max_len = SGF_HUGE_MAX;
        end else if (state_ff.size[SGF_S_LEGAL_SIZE]) begin
            max_len = frm_tagged_i ? SGF_TAG_MAX : SGF_UNTAG_MAX;
        end else begin
            max_len = SGF_DEF_MAX;
        end
        too_long = frm_len_i > max_len;
        // padded frames carry at least the minimum payload
        payload = (frm_len_type_i < SGF_MIN_PAYLOAD) ? SGF_MIN_PAYLOAD : frm_len_type_i;
        exp_len = payload + (frm_tagged_i ? SGF_HDR_TAG : SGF_HDR_UNTAG);
        len_bad = state_ff.flow[SGF_F_LEN_CHK] && (frm_len_type_i < SGF_LEN_TYPE_MAX)
            && (exp_len != {5'h00, frm_len_i});
        age_period = state_ff.flow[SGF_F_FAST_AGE] ? FAST_AGE_CYCLES
            : NORM_AGE_CYCLES;
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_state.rvalid = 1'b0;
        nxt_state.frm_done = 1'b0;
        nxt_state.frm_drop = 1'b0;
        nxt_state.storm = 1'b0;
        nxt_state.fwd_done = 1'b0;
        nxt_state.fwd_allow = 1'b0;
        nxt_state.coll_drop = 1'b0;
        nxt_state.coll_retry = 1'b0;
        nxt_state.age_tick = 1'b0;

        // register writes take effect on the next edge
        if (reg_wr_i && reg_addr_i == SGF_FLOW_OFS) begin
            nxt_state.flow = reg_wdata_i;
        end
        if (reg_wr_i && reg_addr_i == SGF_SIZE_OFS) begin
            nxt_state.size = reg_wdata_i;
        end

        // read answer one cycle after the strobe; unmapped reads zero
        if (reg_rd_i) begin
            nxt_state.rvalid = 1'b1;
            unique case (reg_addr_i)
                SGF_FLOW_OFS: nxt_state.rdata = state_ff.flow;
                SGF_SIZE_OFS: nxt_state.rdata = state_ff.size;
                default: nxt_state.rdata = 8'h00;
            endcase
        end

        // frame acceptance; bad frames pass only in debug sniffing
        if (frm_valid_i) begin
            nxt_state.frm_done = 1'b1;
            nxt_state.frm_drop = too_long || len_bad
                || (frm_bad_i && !state_ff.pass_all);
        end

        // storm regulation counts broadcast, optionally multicast
        if (storm_valid_i) begin
            nxt_state.storm = (&storm_da_i) || (!state_ff.size[SGF_S_BCAST_ONLY]
                && storm_da_i[SGF_DA_MCAST_BIT]);
        end

        // port-vlan crossing
        if (fwd_valid_i) begin
            nxt_state.fwd_done = 1'b1;
            nxt_state.fwd_allow = fwd_same_vlan_i
                || (!state_ff.size[SGF_S_VLAN_STRICT] && fwd_known_uc_i);
        end

        // excessive collisions
        if (coll_valid_i && coll_cnt_i >= SGF_EXCESS_COLL) begin
            nxt_state.coll_drop = !state_ff.size[SGF_S_NO_COLL_DROP];
            nxt_state.coll_retry = state_ff.size[SGF_S_NO_COLL_DROP];
        end

        // fair mode under contention for one destination
        nxt_state.drop_nonfc = contention_i && state_ff.size[SGF_S_FAIR];
        nxt_state.throttle_fc = contention_i && !state_ff.size[SGF_S_FAIR];

        // aging timer; stopped and cleared while aging is off
        if (!state_ff.flow[SGF_F_AGE_EN]) begin
            nxt_state.age_cnt = 32'h0000_0000;
        end else if (state_ff.age_cnt + 32'h0000_0001 >= age_period) begin
            nxt_state.age_cnt = 32'h0000_0000;
            nxt_state.age_tick = 1'b1;
        end else begin
            nxt_state.age_cnt = state_ff.age_cnt + 32'h0000_0001;
        end

        // derived levels
        nxt_state.pass_all = state_ff.flow[SGF_F_PASS_ALL] && sniffer_mode_i;
        nxt_state.mirror_ok = state_ff.size[SGF_S_VLAN_STRICT];
        nxt_state.rsv_bufs = (state_ff.size[SGF_S_PRIO_RSV] && multi_queue_i)
            ? SGF_PRIO_BUFS : 6'h00;

        // synchronous reset; size check bit follows the strap
        if (reset_i) begin
            nxt_state = '0;
            nxt_state.flow = SGF_FLOW_RST;
            nxt_state.size = SGF_SIZE_RST;
            nxt_state.size[SGF_S_LEGAL_SIZE] = size_check_strap_pin_i;
        end
    end

    // state register
    always_ff @(posedge clock_i) begin
        state_ff <= nxt_state;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign reg_rdata_o = state_ff.rdata;
    assign reg_rvalid_o = state_ff.rvalid;
    assign frm_done_o = state_ff.frm_done;
    assign frm_drop_o = state_ff.frm_drop;
    assign storm_count_o = state_ff.storm;
    assign fwd_done_o = state_ff.fwd_done;
    assign fwd_allow_o = state_ff.fwd_allow;
    assign coll_drop_o = state_ff.coll_drop;
    assign coll_retry_o = state_ff.coll_retry;
    assign drop_nonfc_o = state_ff.drop_nonfc;
    assign throttle_fc_o = state_ff.throttle_fc;
    assign age_tick_o = state_ff.age_tick;
    assign pass_all_o = state_ff.pass_all;
    assign tx_pause_en_o = state_ff.flow[SGF_F_TX_PAUSE];
    assign rx_pause_en_o = state_ff.flow[SGF_F_RX_PAUSE];
    assign aggr_backoff_o = state_ff.flow[SGF_F_AGGR_BO];
    assign bp_carrier_o = state_ff.size[SGF_S_BP_CARRIER];
    assign mirror_allowed_o = state_ff.mirror_ok;
    assign rsv_hi_bufs_o = state_ff.rsv_bufs;

endmodule

// ---- rtl/sgf_pkg.sv ----
package sgf_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] SGF_FLOW_OFS = 8'h03;
    localparam logic [7:0] SGF_SIZE_OFS = 8'h04;

    // first register fields
    localparam int SGF_F_PASS_ALL = 7;
    localparam int SGF_F_RSVD = 6;
    localparam int SGF_F_TX_PAUSE = 5;
    localparam int SGF_F_RX_PAUSE = 4;
    localparam int SGF_F_LEN_CHK = 3;
    localparam int SGF_F_AGE_EN = 2;
    localparam int SGF_F_FAST_AGE = 1;
    localparam int SGF_F_AGGR_BO = 0;

    // second register fields
    localparam int SGF_S_VLAN_STRICT = 7;
    localparam int SGF_S_BCAST_ONLY = 6;
    localparam int SGF_S_BP_CARRIER = 5;
    localparam int SGF_S_FAIR = 4;
    localparam int SGF_S_NO_COLL_DROP = 3;
    localparam int SGF_S_HUGE = 2;
    localparam int SGF_S_LEGAL_SIZE = 1;
    localparam int SGF_S_PRIO_RSV = 0;

    // reset values; legal size bit is replaced by the strap level
    localparam logic [7:0] SGF_FLOW_RST = 8'h34;
    localparam logic [7:0] SGF_SIZE_RST = 8'hf1;

    // ----------------------------------------------------------------
    // frame sizes and counts
    // ----------------------------------------------------------------
    localparam logic [15:0] SGF_LEN_TYPE_MAX = 16'h05dc;  // 1500
    localparam logic [15:0] SGF_MIN_PAYLOAD = 16'h002e;   // 46
    localparam logic [15:0] SGF_HDR_UNTAG = 16'h0012;     // 18: da, sa, type, fcs
    localparam logic [15:0] SGF_HDR_TAG = 16'h0016;       // 22 with the vlan tag
    localparam logic [10:0] SGF_HUGE_MAX = 11'h77c;       // 1916
    localparam logic [10:0] SGF_DEF_MAX = 11'h600;        // 1536
    localparam logic [10:0] SGF_TAG_MAX = 11'h5f2;        // 1522
    localparam logic [10:0] SGF_UNTAG_MAX = 11'h5ee;      // 1518
    localparam logic [5:0] SGF_PRIO_BUFS = 6'h30;         // 48
    localparam logic [4:0] SGF_EXCESS_COLL = 5'h10;       // 16
    localparam int SGF_DA_MCAST_BIT = 40;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam longint SGF_CLK_HZ = 64'h0131_2d00;     // 20 MHz
    localparam longint SGF_FAST_AGE_US = 64'h0320;     // 800 us
    localparam longint SGF_NORM_AGE_S = 64'h00c8;      // 200 s
    localparam longint SGF_FAST_AGE_CYC = SGF_FAST_AGE_US * SGF_CLK_HZ / 64'h000f_4240;
    localparam longint SGF_NORM_AGE_CYC = SGF_NORM_AGE_S * SGF_CLK_HZ;

endpackage

// ---- tb/sgf_global_ctrl_sva.sv ----
`timescale 1ns/100ps
module sgf_global_ctrl_sva
    import sgf_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic reg_rvalid_o,
    input wire logic frm_valid_i,
    input wire logic frm_done_o,
    input wire logic frm_drop_o,
    input wire logic fwd_valid_i,
    input wire logic fwd_done_o,
    input wire logic coll_valid_i,
    input wire logic [4:0] coll_cnt_i,
    input wire logic coll_drop_o,
    input wire logic coll_retry_o,
    input wire logic tx_pause_en_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);
    // write of the flow register, a quiet cycle, then its read
    sequence s_flow_wr;
        reg_wr_i && reg_addr_i == SGF_FLOW_OFS;
    endsequence
    sequence s_flow_rd;
        reg_rd_i && !reg_wr_i && reg_addr_i == SGF_FLOW_OFS;
    endsequence
    rd_answer_a: assert property (reg_rd_i |=> reg_rvalid_o)
        else $error("read gave no answer");
    rd_quiet_a: assert property (!reg_rd_i |=> !reg_rvalid_o)
        else $error("answer without read");
    wr_readback_a: assert property (s_flow_wr ##1 !reg_wr_i ##1 s_flow_rd
        |=> reg_rdata_o == $past(reg_wdata_i, 3)) else $error("readback differs");
    unmapped_zero_a: assert property (reg_rd_i && reg_addr_i != SGF_FLOW_OFS
        && reg_addr_i != SGF_SIZE_OFS |=> reg_rdata_o == 8'h00) else $error("unmapped not 0");
    tx_pause_wr_a: assert property (reg_wr_i && reg_addr_i == SGF_FLOW_OFS
        |=> tx_pause_en_o == $past(reg_wdata_i[5])) else $error("tx pause not updated");
    frm_result_a: assert property (frm_valid_i |=> frm_done_o)
        else $error("frame check gave no result");
    frm_drop_gate_a: assert property (!frm_done_o |-> !frm_drop_o)
        else $error("drop without result");
    fwd_result_a: assert property (fwd_valid_i |=> fwd_done_o)
        else $error("forward check gave no result");
    coll_excess_a: assert property (coll_valid_i && coll_cnt_i >= 5'h10
        |=> coll_drop_o ^ coll_retry_o) else $error("excess collision not handled");
    coll_quiet_a: assert property (!(coll_valid_i && coll_cnt_i >= 5'h10)
        |=> !coll_drop_o && !coll_retry_o) else $error("collision result unasked");
endmodule

bind sgf_global_ctrl sgf_global_ctrl_sva i_sgf_global_ctrl_sva (.*);

// ---- tb/sgf_global_ctrl_tb.sv ----
`timescale 1ns/100ps
module sgf_global_ctrl_tb;
    import sgf_pkg::*;
    localparam int LENS[8] = '{64, 1518, 1519, 1522, 1523, 1536, 1916, 1917};
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic size_check_strap_pin_i = 1'b1;
    logic reg_wr_i, reg_rd_i, sniffer_mode_i, multi_queue_i, frm_valid_i, frm_tagged_i;
    logic frm_bad_i, storm_valid_i, fwd_valid_i, fwd_known_uc_i, fwd_same_vlan_i;
    logic coll_valid_i, contention_i, reg_rvalid_o, frm_done_o, frm_drop_o, storm_count_o;
    logic fwd_done_o, fwd_allow_o, coll_drop_o, coll_retry_o, drop_nonfc_o, throttle_fc_o;
    logic age_tick_o, pass_all_o, tx_pause_en_o, rx_pause_en_o, aggr_backoff_o;
    logic mirror_allowed_o, bp_carrier_o;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, flow_m, size_m;
    logic [10:0] frm_len_i;
    logic [15:0] frm_len_type_i;
    logic [47:0] storm_da_i;
    logic [4:0] coll_cnt_i;
    logic [5:0] rsv_hi_bufs_o;
    int num_errors = 0;
    int n_tests = 0;
    int cycles = 0;

    sgf_global_ctrl #(.FAST_AGE_CYCLES(32'h14), .NORM_AGE_CYCLES(32'h32)) i_sgf_global_ctrl (.*);

    // clock and hang guard
    always #25 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors = num_errors + 1;
            results();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // reset for eight edges with the given strap level
    task automatic do_reset(input logic s);
        @(posedge clock_i);
        reset_i <= 1'b1;
        size_check_strap_pin_i <= s;
        repeat (8) @(posedge clock_i);
        reset_i <= 1'b0;
        flow_m = 8'h34;
        size_m = {6'h3c, s, 1'b1};
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
        if (a == 8'h03) flow_m = d;
        if (a == 8'h04) size_m = d;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
        #1;
        chk({reg_rvalid_o, reg_rdata_o}, {1'b1, e});
    endtask

    // expected drop of one frame
    function automatic logic f_drop(logic [10:0] n, logic tg, logic [15:0] lt, logic bad,
                                    logic sn);
        int lim;
        int want;
        lim = size_m[2] ? 1916 : (size_m[1] ? (tg ? 1522 : 1518) : 1536);
        want = (lt < 46 ? 46 : int'(lt)) + (tg ? 22 : 18);
        return n > lim || (flow_m[3] && lt < 1500 && want != n) || (bad && !(flow_m[7] && sn));
    endfunction

    // a random write and readback in two of three steps, levels, then all four request kinds at once
    task automatic step();
        int k;
        logic sn;
        logic mq;
        logic ct;
        logic [10:0] n;
        k = $urandom % 3;
        if (k == 0) wr(8'h03, 8'($urandom) & 8'hbf);
        if (k == 1) wr(8'h04, 8'($urandom));
        if (k < 2) rd(k == 0 ? 8'h03 : 8'h04, k == 0 ? flow_m : size_m);
        n = ($urandom % 2) ? 11'(LENS[$urandom % 8]) : 11'($urandom % 2000);
        sn = 1'($urandom);
        // software mostly follows the advice; a few runs leave the reservation off
        mq = 1'($urandom) & (size_m[0] | ($urandom % 4 == 0));
        ct = 1'($urandom);
        k = $urandom % 3;
        @(posedge clock_i);
        sniffer_mode_i <= sn;
        multi_queue_i <= mq;
        contention_i <= ct;
        @(posedge clock_i);
        {frm_valid_i, storm_valid_i, fwd_valid_i, coll_valid_i} <= 4'hf;
        {frm_tagged_i, frm_bad_i, fwd_known_uc_i, fwd_same_vlan_i} <= 4'($urandom);
        frm_len_i <= n;
        frm_len_type_i <= k == 0 ? 16'(n) - 16'h12 : k == 1 ? 16'h05dc : 16'($urandom % 1600);
        storm_da_i <= ($urandom % 3 == 0) ? '1 : 48'({$urandom, $urandom});
        coll_cnt_i <= ($urandom % 2) ? 5'(15 + $urandom % 3) : 5'($urandom);
        @(posedge clock_i);
        {frm_valid_i, storm_valid_i, fwd_valid_i, coll_valid_i} <= 4'h0;
        #1;
        chk({frm_done_o, frm_drop_o}, {1'b1, f_drop(frm_len_i, frm_tagged_i, frm_len_type_i,
            frm_bad_i, sn)});
        chk({storm_count_o, fwd_done_o, fwd_allow_o}, {&storm_da_i || (!size_m[6] &&
            storm_da_i[40]), 1'b1, fwd_same_vlan_i || (!size_m[7] && fwd_known_uc_i)});
        chk({coll_drop_o, coll_retry_o}, coll_cnt_i >= 16 ? {!size_m[3], size_m[3]} : 2'h0);
        chk({pass_all_o, tx_pause_en_o, rx_pause_en_o, aggr_backoff_o, mirror_allowed_o,
            bp_carrier_o, rsv_hi_bufs_o, drop_nonfc_o, throttle_fc_o}, {flow_m[7] & sn,
            flow_m[5], flow_m[4], flow_m[0], size_m[7], size_m[5], (size_m[0] & mq) ? 6'h30 :
            6'h00, size_m[4] & ct, !size_m[4] & ct});
    endtask

    // main sequence
    initial begin
        int k;
        {reg_wr_i, reg_rd_i, sniffer_mode_i, multi_queue_i, frm_valid_i, frm_tagged_i,
            frm_bad_i, storm_valid_i, fwd_valid_i, fwd_known_uc_i, fwd_same_vlan_i,
            coll_valid_i, contention_i, reg_addr_i, reg_wdata_i, frm_len_i, frm_len_type_i,
            storm_da_i, coll_cnt_i} = '0;
        void'($urandom(34));
        do_reset(1'b1);
        rd(8'h03, 8'h34);
        rd(8'h04, 8'hf3);
        rd(8'h05, 8'h00);
        wr(8'h04, 8'h00);
        rd(8'h04, 8'h00);
        do_reset(1'b0);
        rd(8'h04, 8'hf1);
        for (int i = 0; i < 200; i++) begin
            step();
        end
        // aging fast, normal, then off
        for (int p = 0; p < 3; p++) begin
            wr(8'h03, 8'h30);
            wr(8'h03, p == 0 ? 8'h36 : (p == 1 ? 8'h34 : 8'h30));
            k = 0;
            repeat (p == 1 ? 125 : 50) begin
                @(posedge clock_i);
                #1;
                if (age_tick_o === 1'b1) k++;
            end
            chk(16'(k), p == 2 ? 16'h0000 : 16'h0002);
        end
        results();
    end
endmodule
